// ### include/dac_pd_pkg.sv
// package: constants for the converter power-down and power-on-reset control block
package dac_pd_pkg;
    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS    = 16;
    localparam int OPCODE_MSB    = 15;
    localparam int OPCODE_LSB    = 12;
    localparam int OPERAND_MSB   = 11;
    localparam int MASK_MSB      = 7;
    localparam int CHANNELS      = 8;
    localparam int CODE_BITS     = 12;
    localparam int CHAN_SEL_BITS = 3;
    // ------------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_WRM       = 4'h8;
    localparam logic [3:0] OP_WTM       = 4'h9;
    localparam logic [3:0] OP_UPD_SEL   = 4'hA;
    localparam logic [3:0] OP_ONE_WRITE = 4'hB;
    localparam logic [3:0] OP_BROADCAST = 4'hC;
    localparam logic [3:0] OP_PD_HIZ    = 4'hD;
    localparam logic [3:0] OP_PD_100K   = 4'hE;
    localparam logic [3:0] OP_PD_2K5    = 4'hF;
    // ------------------------------------------------------------------
    // termination codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  TERM_HIZ   = 2'h1;
    localparam logic [1:0]  TERM_100K  = 2'h2;
    localparam logic [1:0]  TERM_2K5   = 2'h3;
    localparam logic [1:0]  TERM_RESET = 2'h0;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [7:0]  PD_RESET   = 8'h00;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ     = 250;
    localparam int RECOVER_US    = 20;
    localparam int RECOVER_CYC   = RECOVER_US * CLOCK_MHZ;
    localparam int RAMP_SHIFT    = 12;
endpackage : dac_pd_pkg

// ### src/dac_code_mem.sv
// memory: eight channel code registers with registered read port
`timescale 1ns/1ps
module dac_code_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8,
    parameter int ABITS = 3
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // write port, code array
    input  wire logic             wr_en,
    input  wire logic [ABITS-1:0] wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_all,
    // read port
    input  wire logic [ABITS-1:0] rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // writes; reset clears every word so outputs start from zero code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (wr_all) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= wr_data;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : dac_code_mem

// ### src/dac_pd_ctrl.sv
// power-on reset and per-channel power-down control of an eight-channel converter
//
// Contract
// - frame is 16 bits; top four bits opcode, low twelve operand
// - supply-monitor reset clears all channel input and output codes to zero
// - outputs stay at zero until a valid frame is written
// - opcodes 1101, 1110, 1111 select hi-z, 100k, 2.5k termination power-down
// - mask bit n selects channel n+1; a one powers it down
// - powered-down channel has core and buffer enables opened
// - bias enabled while any channel active; off only when all eight down
// - power-down never alters channel code registers
// - recovery keeps old code unless the waking frame writes a new one
// - frame receiver keeps decoding regardless of power-down state
// - writes to powered-down channels are stored; otherwise old code persists
// - recovered channel flags settled within 20 us; code ramps woken channels one at a time, each ramp within 20 us of its start
// - recovery ramps output from ground up to the held code
`timescale 1ns/1ps
module dac_pd_ctrl #(
    parameter int RECOVER_CYCLES = dac_pd_pkg::RECOVER_CYC
) (
    // system clock and supply-monitor reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // serial link from host
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        din,
    // channel power controls
    output logic [7:0]       core_enable,
    output logic [7:0]       buffer_enable,
    output logic             bias_enable,
    output logic [7:0]       channel_down,
    output logic [15:0]      termination,
    // channel output levels and status
    output logic [7:0]       settled,
    output logic [11:0]      ramp_code,
    output logic [2:0]       ramp_channel,
    output logic             ramp_valid,
    output logic             write_mode,
    output logic [15:0]      last_frame
);
    // ------------------------------------------------------------------
    // reset synchroniser for the system domain
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // release is synchronised; assertion stays asynchronous
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // link-side reset copy, released on the link clock
    logic lrst_meta;
    logic lrst_n;

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            lrst_meta <= 1'b0;
            lrst_n    <= 1'b0;
        end else begin
            lrst_meta <= 1'b1;
            lrst_n    <= lrst_meta;
        end
    end

    // ------------------------------------------------------------------
    // link domain: frame shift register
    // ------------------------------------------------------------------
    logic [15:0] shift;
    logic [4:0]  bit_count;
    logic [15:0] frame_hold;
    logic        frame_toggle;
    logic        frame_clr_n;

    assign frame_clr_n = lrst_n & ~sync_n; // select high clears at once, sclk may be stopped
    // bit position; a cut frame leaves no stale count for the next one
    always_ff @(negedge sclk or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            bit_count <= '0;
        end else if (bit_count == 5'(dac_pd_pkg::FRAME_BITS - 1)) begin
            bit_count <= '0;
        end else begin
            bit_count <= bit_count + 5'd1;
        end
    end

    // receiver always live
    // data is taken on the falling edge of sclk while select is low
    always_ff @(negedge sclk or negedge lrst_n) begin
        if (!lrst_n) begin
            shift        <= '0;
            frame_hold   <= '0;
            frame_toggle <= 1'b0;
        end else if (!sync_n) begin
            shift <= {shift[14:0], din};
            if (bit_count == 5'(dac_pd_pkg::FRAME_BITS - 1)) begin
                frame_hold   <= {shift[14:0], din};
                frame_toggle <= ~frame_toggle;
            end
        end
    end

    // ------------------------------------------------------------------
    // crossing: toggle synchroniser; data held stable until next frame
    // ------------------------------------------------------------------
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic frame_event;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= frame_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    assign frame_event = tog_sync ^ tog_seen;

    // frame word captured once the toggle has settled across; decoded one kept for observation
    logic [15:0] frame;
    logic        frame_valid;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame       <= '0;
            frame_valid <= 1'b0;
            last_frame  <= '0;
        end else begin
            frame_valid <= frame_event;
            if (frame_event) begin
                frame <= frame_hold;
            end
            if (frame_valid) begin
                last_frame <= frame;
            end
        end
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [3:0]  opcode;
    logic [11:0] operand;
    logic [7:0]  channel_mask;
    logic [2:0]  frame_channel;

    assign opcode        = frame[dac_pd_pkg::OPCODE_MSB:dac_pd_pkg::OPCODE_LSB];
    assign operand       = frame[dac_pd_pkg::OPERAND_MSB:0];
    assign channel_mask  = frame[dac_pd_pkg::MASK_MSB:0];
    assign frame_channel = frame[14:12];

    // one-hot of a channel index
    function automatic logic [7:0] onehot(input logic [2:0] idx);
        onehot = 8'h01 << idx;
    endfunction : onehot

    // pd opcode to termination code
    function automatic logic [1:0] term_of(input logic [3:0] op);
        case (op)
            dac_pd_pkg::OP_PD_HIZ:  term_of = dac_pd_pkg::TERM_HIZ;
            dac_pd_pkg::OP_PD_100K: term_of = dac_pd_pkg::TERM_100K;
            default:                term_of = dac_pd_pkg::TERM_2K5;
        endcase
    endfunction : term_of

    logic       is_pd;
    logic       is_data;
    logic [7:0] update_mask;

    assign is_pd   = frame_valid && (opcode >= dac_pd_pkg::OP_PD_HIZ);
    assign is_data = frame_valid && !frame[15];

    // frames that drive outputs wake the channels they update
    always_comb begin
        update_mask = 8'h00;
        if (frame_valid) begin
            case (opcode)
                dac_pd_pkg::OP_UPD_SEL:   update_mask = channel_mask;
                dac_pd_pkg::OP_ONE_WRITE: update_mask = 8'hFF;
                dac_pd_pkg::OP_BROADCAST: update_mask = 8'hFF;
                default: begin
                    if (!frame[15] && write_mode) begin
                        update_mask = onehot(frame_channel);
                    end
                end
            endcase
        end
    end

    // write-through mode select, register-only after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            write_mode <= 1'b0;
        end else if (frame_valid && opcode == dac_pd_pkg::OP_WTM) begin
            write_mode <= 1'b1;
        end else if (frame_valid && opcode == dac_pd_pkg::OP_WRM) begin
            write_mode <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // code registers (input latches); power-down never touches them
    // ------------------------------------------------------------------
    logic        mem_wr;
    logic [2:0]  mem_addr;
    logic        mem_all;
    logic [2:0]  rd_sel;
    logic [11:0] rd_code;

    // data writes land even on powered-down channels
    // data frames and the one-write opcode write one word; broadcast writes every word
    assign mem_wr   = is_data || (frame_valid && opcode == dac_pd_pkg::OP_ONE_WRITE);
    assign mem_addr = is_data ? frame_channel : 3'd0;
    assign mem_all  = frame_valid && opcode == dac_pd_pkg::OP_BROADCAST;

    dac_code_mem #(.WIDTH(dac_pd_pkg::CODE_BITS), .DEPTH(dac_pd_pkg::CHANNELS),
                   .ABITS(dac_pd_pkg::CHAN_SEL_BITS)) u_mem (
        .clock   (clock),   .rst_n  (rst_n),   .wr_en   (mem_wr), .wr_addr (mem_addr),
        .wr_data (operand), .wr_all (mem_all), .rd_addr (rd_sel), .rd_data (rd_code)
    );

    // ------------------------------------------------------------------
    // power-down state
    // ------------------------------------------------------------------
    // per-channel flag and termination state
    // mask bit n selects channel n+1
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channel_down <= dac_pd_pkg::PD_RESET;
            termination  <= {8{dac_pd_pkg::TERM_RESET}};
        end else begin
            for (int i = 0; i < dac_pd_pkg::CHANNELS; i++) begin
                if (is_pd && channel_mask[i]) begin
                    channel_down[i]       <= 1'b1;
                    termination[2*i +: 2] <= term_of(opcode);
                end else if (update_mask[i]) begin
                    channel_down[i]       <= 1'b0;
                    termination[2*i +: 2] <= dac_pd_pkg::TERM_RESET;
                end
            end
        end
    end

    // core and buffer enables open for downed channels
    // bias off only when all eight down
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_enable   <= 8'h00;
            buffer_enable <= 8'h00;
            bias_enable   <= 1'b0;
        end else begin
            core_enable   <= ~channel_down;
            buffer_enable <= ~channel_down;
            bias_enable   <= ~&channel_down;
        end
    end

    // ------------------------------------------------------------------
    // recovery: ramp from ground to held code, then flag settled
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {RAMP_IDLE, RAMP_READ, RAMP_FETCH, RAMP_RUN} ramp_state_e;
    ramp_state_e ramp_state;
    logic [7:0]  wake_pending;
    logic [31:0] ramp_count;
    logic [2:0]  ramp_idx;
    logic [11:0] target;

    // ramp step scaled so that a full-scale climb ends before the limit
    localparam int STEP_CYC = (RECOVER_CYCLES >> dac_pd_pkg::RAMP_SHIFT) > 0
                            ? (RECOVER_CYCLES >> dac_pd_pkg::RAMP_SHIFT) : 1;

    // remember channels waking up; set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_pending <= 8'h00;
        end else begin
            for (int i = 0; i < dac_pd_pkg::CHANNELS; i++) begin
                if (channel_down[i] && update_mask[i] && !(is_pd && channel_mask[i])) begin
                    wake_pending[i] <= 1'b1;
                end else if (ramp_state == RAMP_FETCH && ramp_idx == 3'(i)) begin
                    wake_pending[i] <= 1'b0;
                end
            end
        end
    end

    // output held at zero until a valid frame updates it
    // settled set when ramp ends, within recovery bound
    // ramp climbs from zero to target
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ramp_state   <= RAMP_IDLE;
            ramp_count   <= '0;
            ramp_idx     <= '0;
            rd_sel       <= '0;
            target       <= '0;
            ramp_code    <= '0;
            ramp_channel <= '0;
            ramp_valid   <= 1'b0;
            settled      <= 8'h00;
        end else begin
            ramp_valid <= 1'b0;
            // downed channels lose their settled mark at once
            settled <= settled & ~channel_down;
            // first update on a live channel settles it directly
            for (int i = 0; i < dac_pd_pkg::CHANNELS; i++) begin
                if (update_mask[i] && !channel_down[i]) begin
                    settled[i] <= 1'b1;
                end
            end
            case (ramp_state)
                RAMP_IDLE: begin
                    for (int i = dac_pd_pkg::CHANNELS - 1; i >= 0; i--) begin
                        if (wake_pending[i]) begin
                            ramp_idx <= 3'(i);
                            rd_sel   <= 3'(i);
                        end
                    end
                    if (|wake_pending) begin
                        ramp_state <= RAMP_READ;
                    end
                end
                RAMP_READ: ramp_state <= RAMP_FETCH; // registered read data lags the address
                RAMP_FETCH: begin
                    target       <= rd_code;
                    ramp_code    <= '0;
                    ramp_count   <= '0;
                    ramp_channel <= ramp_idx;
                    ramp_state   <= RAMP_RUN;
                end
                RAMP_RUN: begin
                    ramp_valid <= 1'b1;
                    if (ramp_code >= target) begin
                        settled[ramp_idx] <= 1'b1;
                        ramp_state        <= RAMP_IDLE;
                    end else if (ramp_count >= 32'(STEP_CYC - 1)) begin
                        ramp_count <= '0;
                        ramp_code  <= ramp_code + 12'd1;
                    end else begin
                        ramp_count <= ramp_count + 32'd1;
                    end
                end
                default: ramp_state <= RAMP_IDLE;
            endcase
        end
    end

endmodule : dac_pd_ctrl

// ### verif/dac_pd_ctrl_bench.sv
// testbench: directed scenarios for the power-down control block
`timescale 1ns/1ps
module dac_pd_ctrl_bench;
    logic        clock;
    logic        arst_n;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic [7:0]  core_enable;
    logic [7:0]  buffer_enable;
    logic        bias_enable;
    logic [7:0]  channel_down;
    logic [15:0] termination;
    logic [7:0]  settled;
    logic [11:0] ramp_code;
    logic [2:0]  ramp_channel;
    logic        ramp_valid;
    logic        write_mode;
    logic [15:0] last_frame;
    int          err_total;
    int          total_checks;
    logic [11:0] codes [8];
    logic [7:0]  seen;

    dac_pd_ctrl uut (
        .clock(clock), .arst_n(arst_n), .sclk(sclk), .sync_n(sync_n), .din(din),
        .core_enable(core_enable), .buffer_enable(buffer_enable),
        .bias_enable(bias_enable), .channel_down(channel_down),
        .termination(termination), .settled(settled), .ramp_code(ramp_code),
        .ramp_channel(ramp_channel), .ramp_valid(ramp_valid),
        .write_mode(write_mode), .last_frame(last_frame)
    );
    serial_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // a frame needs a few clocks to cross into the system domain
    task automatic frame(input logic [15:0] f);
        host.send_bits(f, 16);
        repeat (12) @(negedge clock);
    endtask : frame

    // records the last ramp level of each channel until the masked ones are done
    task automatic watch(input logic [7:0] mask);
        seen = 8'h00;
        for (int n = 0; n < 30000 && !((seen & mask) == mask && !ramp_valid); n++) begin
            @(negedge clock);
            if (ramp_valid === 1'b1) begin
                codes[ramp_channel] = ramp_code;
                seen[ramp_channel]  = 1'b1;
            end
        end
        repeat (4) @(negedge clock);
        chk(16'(seen & mask), 16'(mask), "ramps seen");
        chk(16'(settled & mask), 16'(mask), "settled");
    endtask : watch

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk(16'(channel_down), 16'h0000, "down after reset");
        chk(16'(settled), 16'h0000, "settled after reset");
        chk(termination, 16'h0000, "term after reset");
        chk(16'(bias_enable), 16'h0001, "bias after reset");
    endtask : t_reset

    task automatic t_modes;
        frame(16'h9000);
        chk(16'(write_mode), 16'h0001, "through mode");
        frame(16'h8000);
        chk(16'(write_mode), 16'h0000, "register mode");
        frame(16'h3123);
        chk(last_frame, 16'h3123, "frame seen");
    endtask : t_modes

    task automatic t_pd;
        frame(16'hD0FF);
        chk({core_enable, buffer_enable}, 16'h0000, "enables off");
        chk(16'(bias_enable), 16'h0000, "bias off");
        chk(termination, 16'h5555, "hi-z on all");
        frame(16'hEF82);
        chk(termination, 16'h9559, "100k on 2 and 8");
        frame(16'hF304);
        chk(termination, 16'h9579, "2.5k on 3");
        chk(16'(channel_down), 16'h00ff, "all down");
    endtask : t_pd

    task automatic t_hold;
        host.send_bits(16'hC000, 8);
        repeat (12) @(negedge clock);
        chk(last_frame, 16'hF304, "aborted frame");
        frame(16'h2025);
        chk(16'(channel_down), 16'h00ff, "write keeps down");
        host.send_bits(16'hA004, 16);
        watch(8'h04);
        chk(16'(codes[2]), 16'h0025, "stored code");
        chk(16'(channel_down), 16'h00fb, "only 3 awake");
        host.send_bits(16'hB010, 16);
        watch(8'h09);
        chk(16'(codes[0]), 16'h0010, "new code");
        chk(16'(codes[3]), 16'h0123, "held code");
        chk(16'(channel_down), 16'h0000, "all awake");
    endtask : t_hold

    task automatic t_bcast;
        frame(16'hF0C0);
        chk(16'(channel_down), 16'h00c0, "7 and 8 down");
        host.send_bits(16'hC008, 16);
        watch(8'hc0);
        chk(16'(codes[7]), 16'h0008, "broadcast code");
        chk(termination, 16'h0000, "no termination");
        chk(16'(bias_enable), 16'h0001, "bias back on");
    endtask : t_bcast

    task automatic t_through;
        frame(16'h9000);
        frame(16'hD001);
        host.send_bits(16'h0077, 16);
        watch(8'h01);
        chk(16'(codes[0]), 16'h0077, "through-mode code");
        chk(16'(channel_down), 16'h0000, "through write wakes");
    endtask : t_through

    // ------------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------------
    // 250 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // reset, link-side release pulses, then the scenarios in turn
    initial begin
        err_total    = 0;
        total_checks = 0;
        arst_n       = 1'b0;
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        host.prime(4);
        repeat (4) @(negedge clock);
        t_reset();
        t_modes();
        t_pd();
        t_hold();
        t_bcast();
        t_through();
        wrap_up();
    end

    // whole run needs well under a hundred microseconds
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule : dac_pd_ctrl_bench

// ### verif/dac_pd_ctrl_monitor.sv
// checker: port-level assertions for the power-down control block
`timescale 1ns/1ps
module dac_pd_ctrl_monitor #(
    parameter int RECOVER_CYCLES = dac_pd_pkg::RECOVER_CYC
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // channel power controls
    input wire logic [7:0]  core_enable,
    input wire logic [7:0]  buffer_enable,
    input wire logic        bias_enable,
    input wire logic [7:0]  channel_down,
    input wire logic [15:0] termination,
    // status
    input wire logic [7:0]  settled,
    input wire logic [11:0] ramp_code,
    input wire logic [2:0]  ramp_channel,
    input wire logic        ramp_valid,
    input wire logic        write_mode,
    input wire logic [15:0] last_frame
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [2:0]  up_cnt;
    logic [15:0] ramp_len;
    logic [7:0]  term_nz;
    logic        term_ok;

    // warm-up count hides the two-flop reset release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end

    // length of the ramp of one channel
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) ramp_len <= 16'h0000;
        else if (!ramp_valid || ramp_channel != $past(ramp_channel)) ramp_len <= 16'h0000;
        else if (ramp_len != 16'hffff) ramp_len <= ramp_len + 16'h0001;
    end

    // per-channel termination against the last power-down frame
    always_comb begin
        term_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            term_nz[i] = |termination[2*i +: 2];
            if (last_frame[i] && termination[2*i +: 2] != last_frame[13:12]) term_ok = 1'b0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n || up_cnt != 3'h7);

    sequence s_new;
        $changed(last_frame);
    endsequence
    sequence s_pd;
        s_new ##0 (last_frame[15:12] >= dac_pd_pkg::OP_PD_HIZ);
    endsequence
    sequence s_bcast;
        s_new ##0 (last_frame[15:12] == dac_pd_pkg::OP_BROADCAST);
    endsequence
    sequence s_mode;
        s_new ##0 (last_frame[15:13] == 3'h4);
    endsequence

    reset_clear_a: assert property (disable iff (!arst_n)
        $rose(arst_n) |-> channel_down == 8'h00 && settled == 8'h00 && ramp_code == 12'h000)
        else $error("outputs not cleared at reset release");
    pd_select_a: assert property (s_pd |-> (channel_down & last_frame[7:0]) == last_frame[7:0])
        else $error("selected channel not powered down");
    pd_term_a: assert property (s_pd |-> term_ok)
        else $error("termination does not follow opcode");
    term_state_a: assert property (term_nz == channel_down)
        else $error("termination held for an active channel");
    enable_a: assert property (
        core_enable == buffer_enable && core_enable == ~$past(channel_down))
        else $error("core or buffer enable wrong");
    bias_a: assert property (bias_enable == !(&$past(channel_down)))
        else $error("bias enable wrong");
    bcast_wake_a: assert property (s_bcast |-> channel_down == 8'h00)
        else $error("broadcast left a channel down");
    mode_a: assert property (
        s_mode |-> write_mode == (last_frame[15:12] == dac_pd_pkg::OP_WTM))
        else $error("write mode not taken");
    ramp_start_a: assert property ($rose(ramp_valid) |-> ramp_code <= 12'h001)
        else $error("ramp does not start from ground");
    ramp_step_a: assert property (
        ramp_valid && $past(ramp_valid) && $stable(ramp_channel)
        |-> ramp_code - $past(ramp_code) <= 12'h001)
        else $error("ramp steps too far");
    ramp_len_a: assert property (int'(ramp_len) <= RECOVER_CYCLES)
        else $error("recovery took too long");
endmodule : dac_pd_ctrl_monitor

bind dac_pd_ctrl dac_pd_ctrl_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES)) mon (
    .clock(clock), .arst_n(arst_n), .core_enable(core_enable),
    .buffer_enable(buffer_enable), .bias_enable(bias_enable), .channel_down(channel_down),
    .termination(termination), .settled(settled), .ramp_code(ramp_code),
    .ramp_channel(ramp_channel), .ramp_valid(ramp_valid), .write_mode(write_mode),
    .last_frame(last_frame)
);

// ### verif/serial_host_model.sv
// partner model: serial host that sends command frames to the block
`timescale 1ns/1ps
module serial_host_model #(
    parameter int HALF_NS = 15
) (
    // serial link
    output logic sclk,
    output logic sync_n,
    output logic din
);
    // ------------------------------------------------------------------
    // idle levels and frame driver
    // ------------------------------------------------------------------
    // select high, data low, clock stopped
    initial begin
        sclk   = 1'b0;
        sync_n = 1'b1;
        din    = 1'b0;
    end

    // pulses with select high, only so the link-side reset release can step
    task automatic prime(input int n);
        repeat (n) begin
            #HALF_NS sclk = 1'b1;
            #HALF_NS sclk = 1'b0;
        end
    endtask : prime

    // msb first, data set on the rise, taken on the fall
    task automatic send_bits(input logic [15:0] frame, input int n);
        sync_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            #HALF_NS sclk = 1'b1;
            din = frame[i];
            #HALF_NS sclk = 1'b0;
        end
        #HALF_NS sync_n = 1'b1;
        // data parked low once the frame ends
        din = 1'b0;
    endtask : send_bits
endmodule : serial_host_model
